// ===== pkg/fcn_pkg.sv
// Package for the single-real classify and normalize datapath.
// Assumes: one 125 MHz clock; operands and results come from same-clock pipeline logic.
package fcn_pkg;

  // Word layout: sign on top, 8-bit stored exponent, 23-bit fraction below
  localparam int SIGN_POS = 31;
  localparam int EXP_MSB = 30;
  localparam int EXP_LSB = 23;
  localparam int FRAC_MSB = 22;
  localparam int SIG_W = 24;
  localparam int LZ_W = 5;
  localparam int XEXP_W = 12;

  // Stored exponent values with a meaning of their own
  localparam logic [7:0] EXP_ZERO = 8'h00;
  localparam logic [7:0] EXP_MAX = 8'hff;

  // True exponent limits and bias, 12-bit two's complement
  localparam logic signed [11:0] BIAS = 12'sh07f;
  localparam logic signed [11:0] EMIN = 12'shf82;
  localparam logic signed [11:0] EMAX = 12'sh07f;
  localparam logic signed [11:0] XEXP_SPECIAL = 12'sh080;
  localparam logic signed [11:0] SHIFT_ALL_OUT = 12'sh018;

  // Values after reset
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [23:0] RST_SIG = 24'h00_0000;
  localparam logic [11:0] RST_XEXP = 12'h000;

  // Operand classes
  typedef enum logic [2:0] {
    CLS_ZERO = 3'h0,
    CLS_DENORM = 3'h1,
    CLS_NORMAL = 3'h3,
    CLS_INF = 3'h2,
    CLS_QNAN = 3'h6,
    CLS_SNAN = 3'h7
  } fcn_class_e;

  // Operations requested by the pipeline
  typedef enum logic [1:0] {
    OP_LOAD = 2'h0,
    OP_PACK = 2'h1,
    OP_CMP = 2'h3,
    OP_CHECK = 2'h2
  } fcn_op_e;

endpackage

// ===== logic/fcn_classify.sv
// Field decode and class of one single-real word.
// Assumes: purely combinational, word presented in the same clock domain as the user.
module fcn_classify (
  input wire logic [31:0] i_word,
  output logic o_sign,
  output logic [7:0] o_bexp,
  output logic [22:0] o_frac,
  output fcn_pkg::fcn_class_e o_class
);

  logic exp_zero;
  logic exp_max;
  logic frac_zero;

  // Field split
  assign o_sign = i_word[fcn_pkg::SIGN_POS];
  assign o_bexp = i_word[fcn_pkg::EXP_MSB:fcn_pkg::EXP_LSB];
  assign o_frac = i_word[fcn_pkg::FRAC_MSB:0];

  // Exponent extremes decide the special classes
  assign exp_zero = (o_bexp == fcn_pkg::EXP_ZERO);
  assign exp_max = (o_bexp == fcn_pkg::EXP_MAX);
  assign frac_zero = (o_frac == 23'h00_0000);

  // Sign plays no part in the class itself
  assign o_class = exp_zero ? (frac_zero ? fcn_pkg::CLS_ZERO : fcn_pkg::CLS_DENORM) :
                   !exp_max ? fcn_pkg::CLS_NORMAL :
                   frac_zero ? fcn_pkg::CLS_INF :
                   o_frac[fcn_pkg::FRAC_MSB] ? fcn_pkg::CLS_QNAN : fcn_pkg::CLS_SNAN;

endmodule // fcn_classify

// ===== logic/fcn_norm.sv
// Leading-zero count and left shift of a 24-bit significand.
// Assumes: purely combinational; an all-zero input reports a count of 24.
module fcn_norm (
  input wire logic [23:0] i_sig,
  output logic [4:0] o_lz,
  output logic [23:0] o_sig
);

  // Scan from the low end so the highest set bit wins
  function automatic logic [4:0] lead_zeros(input logic [23:0] s);
    logic [4:0] n;
    n = 5'h18;
    for (int k = 0; k < fcn_pkg::SIG_W; k++)
    begin
      if (s[k])
        n = 5'(fcn_pkg::SIG_W - 1 - k);
    end
    return n;
  endfunction

  // Integer bit ends up set unless the input was zero
  assign o_lz = lead_zeros(i_sig);
  assign o_sig = i_sig << o_lz;

endmodule // fcn_norm

// ===== logic/fcn_top.sv
// Single-real operand classify, normalize, compare and result pack datapath.
// Assumes: requests come from same-clock pipeline logic; one request per cycle, one-cycle latency.
module fcn_top #(
  parameter logic [31:0] P_INDEF = 32'h7fc0_0000
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_VALID,
  input wire logic [1:0] I_OP,
  input wire logic [31:0] I_OPA,
  input wire logic [31:0] I_OPB,
  input wire logic I_RES_SIGN,
  input wire logic [11:0] I_RES_EXP,
  input wire logic [23:0] I_RES_SIG,
  input wire logic I_ZERO_FROM_CANCEL,
  input wire logic I_RND_DOWN,
  input wire logic I_DENORM_MASKED,
  input wire logic I_INVALID_MASKED,
  input wire logic I_INF_INVALID,
  output logic O_VALID,
  output logic [2:0] O_CLASS_A,
  output logic [2:0] O_CLASS_B,
  output logic [31:0] O_RESULT,
  output logic O_XSIGN,
  output logic [11:0] O_XEXP,
  output logic [23:0] O_XSIG,
  output logic O_LT,
  output logic O_EQ,
  output logic O_GT,
  output logic O_UNORD,
  output logic O_UNDERFLOW,
  output logic O_OVERFLOW,
  output logic O_DENORM_OP,
  output logic O_INVALID
);

  // Decoded operand fields
  logic sign_a;
  logic sign_b;
  logic [7:0] bexp_a;
  logic [7:0] bexp_b;
  logic [22:0] frac_a;
  logic [22:0] frac_b;
  fcn_pkg::fcn_class_e cls_a;
  fcn_pkg::fcn_class_e cls_b;

  fcn_classify u_cls_a (
    .i_word(I_OPA),
    .o_sign(sign_a),
    .o_bexp(bexp_a),
    .o_frac(frac_a),
    .o_class(cls_a)
  );

  fcn_classify u_cls_b (
    .i_word(I_OPB),
    .o_sign(sign_b),
    .o_bexp(bexp_b),
    .o_frac(frac_b),
    .o_class(cls_b)
  );

  // Class groups used by several paths
  function automatic logic is_nan(input fcn_pkg::fcn_class_e c);
    return (c == fcn_pkg::CLS_QNAN) || (c == fcn_pkg::CLS_SNAN);
  endfunction

  wire nan_a = is_nan(cls_a);
  wire nan_b = is_nan(cls_b);
  wire snan_any = (cls_a == fcn_pkg::CLS_SNAN) || (cls_b == fcn_pkg::CLS_SNAN);
  wire den_a = (cls_a == fcn_pkg::CLS_DENORM);
  wire den_b = (cls_b == fcn_pkg::CLS_DENORM);
  wire inf_any = (cls_a == fcn_pkg::CLS_INF) || (cls_b == fcn_pkg::CLS_INF);

  // Load path: explicit significand, implied bit made visible
  wire [23:0] load_raw_sig = {(cls_a == fcn_pkg::CLS_NORMAL), frac_a};
  wire signed [11:0] load_true_exp = $signed({4'h0, bexp_a}) - fcn_pkg::BIAS;
  logic [4:0] load_lz;
  logic [23:0] load_norm_sig;

  fcn_norm u_norm_load (
    .i_sig(load_raw_sig),
    .o_lz(load_lz),
    .o_sig(load_norm_sig)
  );

  // Denormal converts either normalized (masked) or left as stored with exponent -126
  wire den_fix = den_a && I_DENORM_MASKED;
  wire signed [11:0] load_den_exp = fcn_pkg::EMIN - $signed({7'h00, load_lz});
  wire signed [11:0] load_xexp =
    (cls_a == fcn_pkg::CLS_ZERO) ? fcn_pkg::RST_XEXP :
    den_fix ? load_den_exp :
    den_a ? fcn_pkg::EMIN :
    (cls_a == fcn_pkg::CLS_NORMAL) ? load_true_exp : fcn_pkg::XEXP_SPECIAL;
  wire [23:0] load_xsig = den_fix ? load_norm_sig : load_raw_sig;

  // Pack path: normalize the raw result first, so a normal form is chosen when it fits
  logic [4:0] pack_lz;
  logic [23:0] pack_norm_sig;

  fcn_norm u_norm_pack (
    .i_sig(I_RES_SIG),
    .o_lz(pack_lz),
    .o_sig(pack_norm_sig)
  );

  wire pack_sig_zero = (I_RES_SIG == fcn_pkg::RST_SIG);
  wire signed [11:0] pack_exp_n = $signed(I_RES_EXP) - $signed({7'h00, pack_lz});
  wire pack_over = !pack_sig_zero && (pack_exp_n > fcn_pkg::EMAX);
  wire pack_tiny = !pack_sig_zero && (pack_exp_n < fcn_pkg::EMIN);
  wire signed [11:0] pack_rshift = fcn_pkg::EMIN - pack_exp_n;
  wire pack_all_out = pack_tiny && (pack_rshift >= fcn_pkg::SHIFT_ALL_OUT);
  wire [23:0] pack_den_sig = pack_all_out ? fcn_pkg::RST_SIG : (pack_norm_sig >> pack_rshift[4:0]);
  wire [7:0] pack_bexp = 8'(pack_exp_n + fcn_pkg::BIAS);

  // Zero sign: exact cancellation takes the rounding direction, else the operation's sign
  wire pack_to_zero = pack_sig_zero || (pack_den_sig == fcn_pkg::RST_SIG && pack_tiny);
  wire zero_sign = I_ZERO_FROM_CANCEL ? I_RND_DOWN : I_RES_SIGN;

  // Assemble the packed word by case
  wire [31:0] pack_word =
    pack_over ? {I_RES_SIGN, fcn_pkg::EXP_MAX, 23'h00_0000} :
    pack_to_zero ? {zero_sign, fcn_pkg::EXP_ZERO, 23'h00_0000} :
    pack_tiny ? {I_RES_SIGN, fcn_pkg::EXP_ZERO, pack_den_sig[22:0]} :
    {I_RES_SIGN, pack_bexp, pack_norm_sig[22:0]};

  // Compare: zeros equal by value, infinities order by their encoding magnitude
  wire [30:0] mag_a = I_OPA[30:0];
  wire [30:0] mag_b = I_OPB[30:0];
  wire both_zero = (cls_a == fcn_pkg::CLS_ZERO) && (cls_b == fcn_pkg::CLS_ZERO);
  wire cmp_unord = nan_a || nan_b;
  wire cmp_eq = !cmp_unord && (both_zero || (I_OPA == I_OPB));
  wire cmp_lt = !cmp_unord && !cmp_eq &&
    ((sign_a && !sign_b) || (sign_a && sign_b && mag_a > mag_b) || (!sign_a && !sign_b && mag_a < mag_b));
  wire cmp_gt = !cmp_unord && !cmp_eq && !cmp_lt;

  // Source check: signaling NaN or an invalid use of infinity; quiet NaN passes through
  wire chk_invalid = snan_any || (inf_any && I_INF_INVALID && !(nan_a || nan_b));
  wire [31:0] chk_qnan = nan_a ? I_OPA : I_OPB;
  wire [31:0] chk_word = (nan_a || nan_b) ? chk_qnan : I_OPA;

  // Per-operation selection of flags and result
  wire op_load = (I_OP == fcn_pkg::OP_LOAD);
  wire op_pack = (I_OP == fcn_pkg::OP_PACK);
  wire op_cmp = (I_OP == fcn_pkg::OP_CMP);
  wire op_chk = (I_OP == fcn_pkg::OP_CHECK);

  wire flag_den = op_load ? den_a : ((op_cmp || op_chk) && (den_a || den_b));
  wire flag_inv = (op_load && cls_a == fcn_pkg::CLS_SNAN) || (op_cmp && snan_any) || (op_chk && chk_invalid);
  wire flag_unf = op_pack && pack_tiny;
  wire flag_ovf = op_pack && pack_over;

  // Masked invalid answers with the indefinite value in place of the result
  wire [31:0] base_word = op_pack ? pack_word : op_chk ? chk_word : I_OPA;
  wire [31:0] result_word = (flag_inv && I_INVALID_MASKED) ? P_INDEF : base_word;

  // Next values of the valid, result, sign, exponent and significand registers
  wire valid_nxt = I_VALID;
  wire [31:0] result_nxt = I_VALID ? result_word : O_RESULT;
  wire xsign_nxt = I_VALID ? sign_a : O_XSIGN;
  wire [11:0] xexp_nxt = (I_VALID && op_load) ? load_xexp : O_XEXP;
  wire [23:0] xsig_nxt = (I_VALID && op_load) ? load_xsig : O_XSIG;

  // Answer strobe, one cycle after each request
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_VALID <= 1'b0;
    else
      O_VALID <= valid_nxt;
  end

  // Flags are one-cycle pulses beside O_VALID, so nothing sticky to clear
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_UNDERFLOW <= 1'b0;
    else
      O_UNDERFLOW <= I_VALID && flag_unf;
  end

  // Overflow pulse; the packed word is already the signed infinity
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_OVERFLOW <= 1'b0;
    else
      O_OVERFLOW <= I_VALID && flag_ovf;
  end

  // Denormal source pulse, raised whether or not the operand is normalized
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_DENORM_OP <= 1'b0;
    else
      O_DENORM_OP <= I_VALID && flag_den;
  end

  // Invalid pulse; when I_INVALID_MASKED is set the result already carries P_INDEF, otherwise the user handles it
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_INVALID <= 1'b0;
    else
      O_INVALID <= I_VALID && flag_inv;
  end

  // Compare outcome pulses only for a compare request
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_LT <= 1'b0;
    else
      O_LT <= I_VALID && op_cmp && cmp_lt;
  end

  // Equal covers both zeros, so the sign bit never splits them
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_EQ <= 1'b0;
    else
      O_EQ <= I_VALID && op_cmp && cmp_eq;
  end

  // Greater is whatever is left of an ordered compare
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_GT <= 1'b0;
    else
      O_GT <= I_VALID && op_cmp && cmp_gt;
  end

  // Unordered whenever either side is a NaN of any kind
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_UNORD <= 1'b0;
    else
      O_UNORD <= I_VALID && op_cmp && cmp_unord;
  end

  // Data outputs hold their last value between requests
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_RESULT <= fcn_pkg::RST_WORD;
    else
      O_RESULT <= result_nxt;
  end

  // Sign of operand A, held with the result
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_XSIGN <= 1'b0;
    else
      O_XSIGN <= xsign_nxt;
  end

  // Internal exponent moves only on a load, so other requests keep it
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_XEXP <= fcn_pkg::RST_XEXP;
    else
      O_XEXP <= xexp_nxt;
  end

  // Explicit significand, load only
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_XSIG <= fcn_pkg::RST_SIG;
    else
      O_XSIG <= xsig_nxt;
  end

  // Class of operand A
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_CLASS_A <= fcn_pkg::CLS_ZERO;
    else
      O_CLASS_A <= I_VALID ? cls_a : O_CLASS_A;
  end

  // Class of operand B, meaningful for compare and check
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_CLASS_B <= fcn_pkg::CLS_ZERO;
    else
      O_CLASS_B <= I_VALID ? cls_b : O_CLASS_B;
  end

endmodule // fcn_top

// ===== sim/fcn_pipe_model.sv
// Consumer half of the pipeline that feeds the datapath.
// Assumes: same clock as the datapath; answers arrive as one-cycle pulses.
module fcn_pipe_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [31:0] i_result,
  output logic [31:0] o_last,
  output int o_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // Capture every answer; the pipeline never stalls, so nothing is held back
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_last <= 32'h0;
      o_count <= 0;
    end
    else if (i_valid)
    begin
      o_last <= i_result;
      o_count <= o_count + 1;
    end
  end
endmodule // fcn_pipe_model

// ===== sim/fcn_top_monitor.sv
// Port checker for the classify and normalize datapath.
// Assumes: bound into fcn_top; one clock, asynchronous active-high reset.
module fcn_top_monitor (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_VALID,
  input wire logic [1:0] I_OP,
  input wire logic [31:0] I_OPA,
  input wire logic [11:0] I_RES_EXP,
  input wire logic [23:0] I_RES_SIG,
  input wire logic I_ZERO_FROM_CANCEL,
  input wire logic O_VALID,
  input wire logic [2:0] O_CLASS_A,
  input wire logic [31:0] O_RESULT,
  input wire logic O_OVERFLOW,
  input wire logic O_DENORM_OP
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  // Field decode of operand A
  wire logic [7:0] ea = I_OPA[30:23];
  wire logic fz = (I_OPA[22:0] == 23'h0);
  wire logic ld = I_VALID && (I_OP == 2'h0);
  // Overflow needs a normalized significand above the top exponent
  sequence s_pack_ovf;
    I_VALID && I_OP == 2'h1 && !I_ZERO_FROM_CANCEL && I_RES_SIG[23] && $signed(I_RES_EXP) > 12'sh07f;
  endsequence
  sequence s_inf_out;
    O_OVERFLOW && O_RESULT[30:0] == 31'h7f800000;
  endsequence
  a_answer_next: assert property (I_VALID |=> O_VALID) else $error("answer missing");
  a_no_spurious: assert property (!I_VALID |=> !O_VALID) else $error("answer without request");
  a_result_holds: assert property (!I_VALID |=> $stable(O_RESULT)) else $error("result moved");
  a_normal_class: assert property (ld && ea != 8'h00 && ea != 8'hff |=> O_CLASS_A == 3'h3)
    else $error("normal class wrong");
  a_zero_class: assert property (ld && ea == 8'h00 && fz |=> O_CLASS_A == 3'h0)
    else $error("zero class wrong");
  a_denorm_flag: assert property (ld && ea == 8'h00 && !fz |=> O_DENORM_OP && O_CLASS_A == 3'h1)
    else $error("denormal operand missed");
  a_inf_class: assert property (ld && ea == 8'hff && fz |=> O_CLASS_A == 3'h2)
    else $error("infinity class wrong");
  a_nan_kind: assert property (ld && ea == 8'hff && !fz |=> O_CLASS_A == {2'h3, !$past(I_OPA[22])})
    else $error("nan subclass wrong");
  a_pack_ovf: assert property (s_pack_ovf |=> s_inf_out) else $error("overflow not infinity");
endmodule // fcn_top_monitor

bind fcn_top fcn_top_monitor u_mon (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_VALID(I_VALID),
  .I_OP(I_OP), .I_OPA(I_OPA), .I_RES_EXP(I_RES_EXP), .I_RES_SIG(I_RES_SIG),
  .I_ZERO_FROM_CANCEL(I_ZERO_FROM_CANCEL), .O_VALID(O_VALID), .O_CLASS_A(O_CLASS_A),
  .O_RESULT(O_RESULT), .O_OVERFLOW(O_OVERFLOW), .O_DENORM_OP(O_DENORM_OP));

// ===== sim/fcn_top_tb.sv
// Self-checking bench for the classify and normalize datapath.
// Assumes: one-cycle answer after each request, no back-pressure.
module fcn_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, vld = 0, rs = 0, zc = 0, rd = 0, dm = 1, im = 1, ii = 0;
  logic [1:0] op = 2'h0;
  logic [31:0] a = 32'h0, b = 32'h0;
  logic [11:0] re = 12'h0;
  logic [23:0] rg = 24'h0;
  logic ov, xs, lt, eq, gt, un, uf, of, dn, inv;
  logic [2:0] ca, cb;
  logic [31:0] res, last;
  logic [11:0] xe;
  logic [23:0] xg;
  int err_total = 0, cmp_count = 0, cyc = 0, got;
  fcn_top DUT (.I_CLK_SYS(clk), .I_RST(rst), .I_VALID(vld), .I_OP(op), .I_OPA(a), .I_OPB(b),
    .I_RES_SIGN(rs), .I_RES_EXP(re), .I_RES_SIG(rg), .I_ZERO_FROM_CANCEL(zc), .I_RND_DOWN(rd),
    .I_DENORM_MASKED(dm), .I_INVALID_MASKED(im), .I_INF_INVALID(ii), .O_VALID(ov),
    .O_CLASS_A(ca), .O_CLASS_B(cb), .O_RESULT(res), .O_XSIGN(xs), .O_XEXP(xe), .O_XSIG(xg),
    .O_LT(lt), .O_EQ(eq), .O_GT(gt), .O_UNORD(un), .O_UNDERFLOW(uf), .O_OVERFLOW(of),
    .O_DENORM_OP(dn), .O_INVALID(inv));
  fcn_pipe_model u_pipe (.i_clk(clk), .i_rst(rst), .i_valid(ov), .i_result(res),
    .o_last(last), .o_count(got));
  // 8 ns period
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One request, answer sampled just after the following edge
  task automatic req(input logic [1:0] o, input logic [31:0] x, input logic [31:0] y);
    @(posedge clk);
    vld <= 1'b1;
    op <= o;
    a <= x;
    b <= y;
    @(posedge clk);
    vld <= 1'b0;
    #1;
    chk("valid", ov, 1);
  endtask
  task automatic pack(input logic s, input logic [11:0] e, input logic [23:0] g, input logic [31:0] w);
    @(posedge clk);
    rs <= s;
    re <= e;
    rg <= g;
    req(2'h1, 0, 0);
    chk("pack", res, w);
  endtask
  // Class, sign and true exponent of loaded words
  task automatic t_load;
    logic [31:0] w[8] = '{32'h0, 32'h80000000, 32'h43322000, 32'hff800000,
      32'h7fc00001, 32'h7f800001, 32'h7f7fffff, 32'h00800000};
    logic [2:0] c[8] = '{3'h0, 3'h0, 3'h3, 3'h2, 3'h6, 3'h7, 3'h3, 3'h3};
    logic [11:0] e[8] = '{12'h0, 12'h0, 12'h7, 12'h80, 12'h80, 12'h80, 12'h7f, 12'hf82};
    for (int i = 0; i < 8; i++)
    begin
      req(2'h0, w[i], 0);
      chk("class", ca, c[i]);
      chk("sign", xs, w[i][31]);
      chk("xexp", xe, e[i]);
      chk("invalid", inv, i == 5);
    end
    chk("xsig", xg, 24'h800000);
  endtask
  task automatic t_denorm;
    req(2'h0, 32'h00000001, 0);
    chk("dnflag", dn, 1);
    chk("dnexp", xe, 12'hf6b);
    chk("dnsig", xg, 24'h800000);
    dm <= 1'b0;
    req(2'h0, 32'h00400000, 0);
    chk("rawexp", xe, 12'hf82);
    chk("rawsig", xg, 24'h400000);
    dm <= 1'b1;
  endtask
  task automatic t_pack;
    pack(0, 12'hf7f, 24'hae0000, 32'h0015c000);
    chk("uflow", uf, 1);
    pack(0, 12'h007, 24'hb22000, 32'h43322000);
    chk("uflow", uf, 0);
    pack(0, 12'h000, 24'h400000, 32'h3f000000);
    pack(0, 12'hf60, 24'h800000, 32'h0);
    pack(1, 12'h080, 24'h800000, 32'hff800000);
    chk("oflow", of, 1);
    zc <= 1'b1;
    rd <= 1'b1;
    pack(0, 12'h0, 24'h0, 32'h80000000);
    rd <= 1'b0;
    pack(1, 12'h0, 24'h0, 32'h0);
    zc <= 1'b0;
  endtask
  task automatic t_cmp;
    req(2'h3, 32'hff800000, 32'h7f7fffff);
    chk("lt", lt, 1);
    chk("classb", cb, 3'h3);
    req(2'h3, 32'h7f800000, 32'h3f800000);
    chk("gt", gt, 1);
    req(2'h3, 32'h80000000, 32'h0);
    chk("eq", eq, 1);
    chk("keep", res, 32'h80000000);
    req(2'h3, 32'h7fc00000, 32'h0);
    chk("unord", {un, inv}, 2'h2);
    im <= 1'b0;
    req(2'h3, 32'h7f800001, 32'h0);
    chk("snan", inv, 1);
    im <= 1'b1;
  endtask
  task automatic t_check;
    req(2'h2, 32'h00000000, 32'h7fc00001);
    chk("qpass", res, 32'h7fc00001);
    chk("qinv", inv, 0);
    chk("qclassb", cb, 3'h6);
    req(2'h2, 32'h7f800000, 32'hff800000);
    chk("exact", inv, 0);
    ii <= 1'b1;
    req(2'h2, 32'h7f800000, 32'hff800000);
    chk("infinv", inv, 1);
    chk("indef", res, 32'h7fc00000);
    ii <= 1'b0;
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard, far above the roughly 70 cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      complete_run();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_load();
    t_denorm();
    t_pack();
    t_cmp();
    t_check();
    @(posedge clk);
    #1;
    chk("consumed", got, 25);
    chk("lastres", last, 32'h7fc00000);
    complete_run();
  end
endmodule // fcn_top_tb
